// ---- verilog/dac_defs.vh ----
// Constants for the device access request checker.
// Assumes one 200 MHz clock; included by dac_checker.v only.
`ifndef DAC_DEFS_VH
`define DAC_DEFS_VH
// ----------------------------------------------------------------
// Frame types
// ----------------------------------------------------------------
`define DAC_FRAME_3E      2'h1
`define DAC_FRAME_4E      2'h2
`define DAC_FRAME_1E      2'h0
// ----------------------------------------------------------------
// Device codes
// ----------------------------------------------------------------
`define DAC_CODE_SM       8'h91
`define DAC_CODE_SD       8'ha9
`define DAC_CODE_IN       8'h9c
`define DAC_CODE_OUT      8'h9d
`define DAC_CODE_M        8'h90
`define DAC_CODE_F        8'h93
`define DAC_CODE_B        8'ha0
`define DAC_CODE_D        8'ha8
`define DAC_CODE_W        8'hb4
`define DAC_CODE_MOT      8'he0
`define DAC_CODE_DIN      8'ha2
`define DAC_CODE_DOUT     8'ha3
// ----------------------------------------------------------------
// Highest device numbers
// ----------------------------------------------------------------
`define DAC_MAX_SYS       23'h0008cf
`define DAC_MAX_IO        23'h001fff
`define DAC_MAX_M         23'h002fff
`define DAC_MAX_F         23'h0007ff
`define DAC_MAX_D         23'h001fff
`define DAC_MAX_D_ADV     23'h004d6f
`define DAC_MAX_DIRECT    23'h000fff
`define DAC_MAX_EXT_ASC   23'h0f423f
`define DAC_MAX_EXT_BIN   23'h3fd7ff
// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define DAC_ST_OK         16'h0000
`define DAC_ST_RANGE      16'hc056
`define DAC_ST_CMD        16'hc059
`define DAC_ST_DEVICE     16'hc05b
`define DAC_ST_ROUTE      16'hc05f
`define DAC_ST_ASCII      16'hc050
`endif

// ---- verilog/dac_checker.v ----
// Request checker for the service Ethernet port.
// Assumes a decoded request from the same clock domain and a
// response engine that pulses rsp_done when a UDP answer has left.
`include "dac_defs.vh"
module dac_checker #(
  parameter NPORT = 4,
  parameter PW    = 16
) (
  input  wire                 mclk,
  input  wire                 rstn,
  input  wire                 req_valid,
  input  wire [1:0]           req_frame,
  input  wire                 req_ascii,
  input  wire [7:0]           req_code,
  input  wire [7:0]           req_chr0,
  input  wire [7:0]           req_chr1,
  input  wire                 req_ext,
  input  wire                 req_local,
  input  wire                 req_remote_cpu,
  input  wire                 req_relay,
  input  wire                 req_udp,
  input  wire [PW-1:0]        req_port,
  input  wire [22:0]          req_start,
  input  wire [15:0]          req_count,
  input  wire                 adv_sync_mode,
  input  wire                 ext_cfg_valid,
  input  wire [22:0]          ext_cfg_max,
  input  wire                 rsp_done,
  input  wire [PW-1:0]        rsp_port,
  output reg                  chk_valid_ff,
  output reg                  chk_accept_ff,
  output reg                  chk_drop_ff,
  output reg  [15:0]          chk_status_ff,
  output reg  [7:0]           chk_code_ff
);
  // --------------------------------------------------------------
  // ASCII code map
  // --------------------------------------------------------------
  reg  [7:0]  asc_code;
  reg         asc_ok;
  // Letters of the ASCII device names
  localparam [7:0] CH_STAR  = 8'h2a;
  localparam [7:0] CH_BLANK = 8'h20;
  localparam [7:0] CH_X     = 8'h58;
  localparam [7:0] CH_Y     = 8'h59;
  localparam [7:0] CH_M     = 8'h4d;
  localparam [7:0] CH_F     = 8'h46;
  localparam [7:0] CH_B     = 8'h42;
  localparam [7:0] CH_D     = 8'h44;
  localparam [7:0] CH_W     = 8'h57;
  localparam [7:0] CH_HASH  = 8'h23;
  localparam [7:0] CH_S     = 8'h53;
  always @* begin
    asc_code = 8'h00;
    asc_ok   = 1'b1;
    if (req_chr1 == CH_STAR || req_chr1 == CH_BLANK) begin
      case (req_chr0)
        CH_X:    asc_code = `DAC_CODE_IN;
        CH_Y:    asc_code = `DAC_CODE_OUT;
        CH_M:    asc_code = `DAC_CODE_M;
        CH_F:    asc_code = `DAC_CODE_F;
        CH_B:    asc_code = `DAC_CODE_B;
        CH_D:    asc_code = `DAC_CODE_D;
        CH_W:    asc_code = `DAC_CODE_W;
        CH_HASH: asc_code = `DAC_CODE_MOT;
        default: asc_ok = 1'b0;
      endcase
    end else begin
      case ({req_chr0, req_chr1})
        {CH_S, CH_M}: asc_code = `DAC_CODE_SM;
        {CH_S, CH_D}: asc_code = `DAC_CODE_SD;
        {CH_D, CH_X}: asc_code = `DAC_CODE_DIN;
        {CH_D, CH_Y}: asc_code = `DAC_CODE_DOUT;
        default:      asc_ok = 1'b0;
      endcase
    end
  end
  // --------------------------------------------------------------
  // Device table and limits
  // --------------------------------------------------------------
  wire [7:0]  code = req_ascii ? asc_code : req_code;
  reg  [22:0] lim;
  reg         known;
  always @* begin
    lim   = 23'h000000;
    known = 1'b1;
    case (code)
      `DAC_CODE_SM, `DAC_CODE_SD: lim = `DAC_MAX_SYS;
      `DAC_CODE_IN:               lim = `DAC_MAX_IO;
      `DAC_CODE_OUT:              lim = `DAC_MAX_IO;
      `DAC_CODE_M, `DAC_CODE_MOT: lim = `DAC_MAX_M;
      `DAC_CODE_F:                lim = `DAC_MAX_F;
      `DAC_CODE_B, `DAC_CODE_W:   lim = `DAC_MAX_IO;
      `DAC_CODE_DIN, `DAC_CODE_DOUT:
        lim = `DAC_MAX_DIRECT;
      `DAC_CODE_D: begin
        if (req_ext) begin
          lim = ext_cfg_valid ? ext_cfg_max : `DAC_MAX_EXT_BIN;
          if (req_ascii && lim > `DAC_MAX_EXT_ASC)
            lim = `DAC_MAX_EXT_ASC;
        end else begin
          lim = adv_sync_mode ? `DAC_MAX_D_ADV : `DAC_MAX_D;
        end
      end
      default: known = 1'b0;
    endcase
    if (req_ascii && !asc_ok)
      known = 1'b0;
  end
  // Last point must stay inside; a zero count is a range fault too
  wire [23:0] last     = {1'b0, req_start} + {8'h00, req_count}
                         - 24'h000001;
  wire        in_range = (req_count != 16'h0000) &&
                         (last <= {1'b0, lim});
  // --------------------------------------------------------------
  // UDP pending table, one entry per port number
  // --------------------------------------------------------------
  // Keyed by port number so duplicate settings share one entry
  reg  [PW-1:0]    pend_port_ff [0:NPORT-1];
  reg  [NPORT-1:0] pend_busy_ff;
  wire [NPORT-1:0] hit;
  wire [NPORT-1:0] done_hit;
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_ent
      assign hit[g]      = pend_busy_ff[g] &&
                           pend_port_ff[g] == req_port;
      assign done_hit[g] = pend_busy_ff[g] &&
                           pend_port_ff[g] == rsp_port;
    end
  endgenerate
  // Lowest free entry; a full table drops the request
  reg  [NPORT-1:0] free_sel;
  integer i;
  always @* begin
    free_sel = {NPORT{1'b0}};
    for (i = NPORT - 1; i >= 0; i = i - 1)
      if (!pend_busy_ff[i])
        free_sel = {{NPORT{1'b0}}} | ({{NPORT-1{1'b0}}, 1'b1} << i);
  end
  wire udp_drop = req_udp && ((|hit) || free_sel == {NPORT{1'b0}});
  // --------------------------------------------------------------
  // Verdict, highest priority first
  // --------------------------------------------------------------
  reg  [15:0] nxt_status;
  // Route faults after the frame check, before device faults: a foreign target makes the device moot
  always @* begin
    if (req_frame != `DAC_FRAME_3E)
      nxt_status = `DAC_ST_CMD;
    else if (req_remote_cpu || req_relay)
      nxt_status = `DAC_ST_ROUTE;
    else if (req_local)
      nxt_status = `DAC_ST_DEVICE;
    else if (!known)
      nxt_status = `DAC_ST_DEVICE;
    else if (!in_range)
      nxt_status = `DAC_ST_RANGE;
    else
      nxt_status = `DAC_ST_OK;
  end
  wire take = req_valid && !udp_drop;
  // An errored UDP request is still answered, so it holds its port
  wire ent  = req_valid && req_udp && !udp_drop;
  // --------------------------------------------------------------
  // Pending table update
  // --------------------------------------------------------------
  reg  [NPORT-1:0] nxt_pend_busy;
  always @* begin
    nxt_pend_busy = pend_busy_ff;
    if (rsp_done)
      nxt_pend_busy = nxt_pend_busy & ~done_hit;
    // New entry wins over a same-cycle release elsewhere
    if (ent)
      nxt_pend_busy = nxt_pend_busy | free_sel;
  end
  // --------------------------------------------------------------
  // Registered verdict and pending flags
  // --------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chk_valid_ff  <= 1'b0;
      chk_accept_ff <= 1'b0;
      chk_drop_ff   <= 1'b0;
      chk_status_ff <= 16'h0000;
      chk_code_ff   <= 8'h00;
      pend_busy_ff  <= {NPORT{1'b0}};
    end else begin
      chk_valid_ff  <= take;
      chk_drop_ff   <= req_valid && udp_drop;
      chk_accept_ff <= take && nxt_status == `DAC_ST_OK;
      if (take) begin
        chk_status_ff <= nxt_status;
        chk_code_ff   <= code;
      end
      pend_busy_ff  <= nxt_pend_busy;
    end
  end
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      always @(posedge mclk or negedge rstn) begin
        if (!rstn)
          pend_port_ff[g] <= {PW{1'b0}};
        else if (ent && free_sel[g])
          pend_port_ff[g] <= req_port;
      end
    end
  endgenerate
endmodule

// ---- verif/dac_checker_asserts.sv ----
// Verdict timing and priority checks for the request checker.
// Assumes one clock domain; bound into every dac_checker.
module dac_checker_asserts (
  input logic        mclk,
  input logic        rstn,
  input logic        req_valid,
  input logic [1:0]  req_frame,
  input logic        req_ascii,
  input logic [7:0]  req_code,
  input logic        req_local,
  input logic        req_remote_cpu,
  input logic        req_relay,
  input logic        req_udp,
  input logic [22:0] req_start,
  input logic [15:0] req_count,
  input logic        chk_valid_ff,
  input logic        chk_accept_ff,
  input logic        chk_drop_ff,
  input logic [15:0] chk_status_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // UDP requests left out: a pending port may drop them
  wire ok_hdr = req_valid && !req_udp && req_frame == 2'h1;
  wire clean  = ok_hdr && !req_remote_cpu && !req_relay && !req_local;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_FRAME: assert property (
    req_valid && !req_udp && req_frame != 2'h1
    |=> chk_valid_ff && chk_status_ff == 16'hc059) else $error("frame");
  AST_ROUTE: assert property (
    ok_hdr && req_remote_cpu |=> chk_status_ff == 16'hc05f)
    else $error("route");
  AST_RELAY: assert property (
    ok_hdr && req_relay |=> chk_status_ff == 16'hc05f) else $error("relay");
  AST_LOCAL: assert property (
    ok_hdr && !req_remote_cpu && !req_relay && req_local
    |=> chk_status_ff == 16'hc05b) else $error("local");
  AST_INPUT_OK: assert property (
    clean && !req_ascii && req_code == 8'h9c && req_count != 0
    && req_start + req_count <= 24'h2000 |=> chk_accept_ff)
    else $error("input area");
  AST_ANSWER: assert property (
    req_valid |=> chk_valid_ff != chk_drop_ff) else $error("answer");
  AST_ACCEPT: assert property (
    chk_accept_ff |-> chk_valid_ff && chk_status_ff == 16'h0000)
    else $error("accept");
  AST_DROP: assert property (
    chk_drop_ff |-> !chk_valid_ff && $stable(chk_status_ff))
    else $error("drop");
  cover property (chk_drop_ff);
  cover property (chk_accept_ff);
  cover property (chk_valid_ff && chk_status_ff == 16'hc056);
endmodule

bind dac_checker dac_checker_asserts dac_checker_asserts_i (.*);

// ---- verif/dac_host_model.sv ----
// Host side: sends the UDP answer for one port after a delay.
// Assumes go is a one-cycle pulse from the bench.
module dac_host_model (
  input  logic        mclk,
  input  logic        rstn,
  input  logic        go,
  input  logic [15:0] port,
  input  logic [7:0]  delay,
  output logic        rsp_done,
  output logic [15:0] rsp_port
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic       busy_ff;
  // ------------------------------------------------------------
  // Answer timer
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {busy_ff, cnt_ff, rsp_done, rsp_port} <= '0;
    end else begin
      rsp_done <= busy_ff && cnt_ff == 0;
      // Idle port lines toggle so stale values never match
      rsp_port <= (busy_ff && cnt_ff == 0) ? port : ~rsp_port;
      busy_ff  <= go || (busy_ff && cnt_ff != 0);
      cnt_ff   <= go ? delay : cnt_ff - (cnt_ff != 0);
    end
  end
endmodule

// ---- verif/dac_checker_bench.sv ----
// Self-checking bench for dac_checker.
// Assumes a 200 MHz clock; inputs change at the falling edge.
module dac_checker_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, rstn = 0, req_valid = 0, req_ascii = 0;
  logic        req_ext = 0, req_local = 0, req_remote_cpu = 0;
  logic        req_relay = 0, req_udp = 0, adv_sync_mode = 0;
  logic        ext_cfg_valid = 0, go = 0, rsp_done;
  logic        chk_valid_ff, chk_accept_ff, chk_drop_ff;
  logic [1:0]  req_frame = 2'h1;
  logic [7:0]  req_code = 0, req_chr0 = 0, req_chr1 = 0, chk_code_ff;
  logic [15:0] req_port = 0, req_count = 0, rsp_port, chk_status_ff;
  logic [22:0] req_start = 0, ext_cfg_max = 0;
  int          fails = 0, n_compared = 0;
  always #2.5 mclk = ~mclk;
  dac_checker dac_checker_i (
    .mclk(mclk), .rstn(rstn), .req_valid(req_valid),
    .req_frame(req_frame), .req_ascii(req_ascii), .req_code(req_code),
    .req_chr0(req_chr0), .req_chr1(req_chr1), .req_ext(req_ext),
    .req_local(req_local), .req_remote_cpu(req_remote_cpu),
    .req_relay(req_relay), .req_udp(req_udp), .req_port(req_port),
    .req_start(req_start), .req_count(req_count),
    .adv_sync_mode(adv_sync_mode), .ext_cfg_valid(ext_cfg_valid),
    .ext_cfg_max(ext_cfg_max), .rsp_done(rsp_done),
    .rsp_port(rsp_port), .chk_valid_ff(chk_valid_ff),
    .chk_accept_ff(chk_accept_ff), .chk_drop_ff(chk_drop_ff),
    .chk_status_ff(chk_status_ff), .chk_code_ff(chk_code_ff));
  dac_host_model dac_host_model_i (.mclk(mclk), .rstn(rstn), .go(go),
    .port(req_port), .delay(8'h03), .rsp_done(rsp_done),
    .rsp_port(rsp_port));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input [15:0] got, input [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Expected ffff means silently dropped
  task rq(input [7:0] c, input [22:0] s, input [15:0] n, input [15:0] e);
    {req_code, req_start, req_count, req_valid} = {c, s, n, 1'b1};
    @(negedge mclk);
    req_valid = 0;
    // Valid, accept and drop stand for one cycle only
    chk({chk_valid_ff, chk_accept_ff, chk_drop_ff},
        e == 16'hffff ? 3'b001 : {1'b1, e == 16'h0, 1'b0});
    if (e != 16'hffff) chk(chk_status_ff, e);
    @(negedge mclk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_hdr;
    for (int f = 0; f < 4; f++) begin
      req_frame = f[1:0];
      rq(8'ha8, 0, 1, f == 1 ? 16'h0 : 16'hc059);
    end
    req_frame = 2'h1;
    req_remote_cpu = 1;
    rq(8'ha8, 0, 1, 16'hc05f);
    {req_remote_cpu, req_relay} = 2'b01;
    rq(8'ha8, 0, 1, 16'hc05f);
    {req_relay, req_local} = 2'b01;
    rq(8'ha8, 0, 1, 16'hc05b);
    req_local = 0;
    $display("header test done");
  endtask
  task t_range;
    rq(8'h9c, 23'h1fff, 1, 16'h0);
    rq(8'h9c, 23'h1fff, 2, 16'hc056);
    rq(8'h9d, 23'h1ffe, 2, 16'h0);
    rq(8'h9d, 23'h1ffe, 3, 16'hc056);
    rq(8'ha2, 23'hfff, 1, 16'h0);
    rq(8'ha3, 23'h1000, 1, 16'hc056);
    rq(8'h55, 0, 1, 16'hc05b);
    rq(8'h9c, 0, 0, 16'hc056);
    rq(8'ha8, 23'd8192, 1, 16'hc056);
    adv_sync_mode = 1;
    rq(8'ha8, 23'd19823, 1, 16'h0);
    rq(8'ha8, 23'd19823, 2, 16'hc056);
    adv_sync_mode = 0;
    $display("range test done");
  endtask
  task t_ext;
    req_ext = 1;
    rq(8'ha8, 23'd4184063, 1, 16'h0);
    rq(8'ha8, 23'd4184064, 1, 16'hc056);
    {ext_cfg_valid, ext_cfg_max} = {1'b1, 23'd100};
    rq(8'ha8, 23'd100, 1, 16'h0);
    rq(8'ha8, 23'd101, 1, 16'hc056);
    {req_ascii, ext_cfg_max, req_chr0, req_chr1} = {1'b1, 23'd2000000, 16'h442a};
    rq(8'h00, 23'd999999, 1, 16'h0);
    rq(8'h00, 23'd1000000, 1, 16'hc056);
    {req_ext, ext_cfg_valid, req_chr0, req_chr1} = {2'b00, 16'h5820};
    rq(8'h00, 23'h1fff, 1, 16'h0);
    chk(chk_code_ff, 16'h009c);
    req_ascii = 0;
    $display("extended test done");
  endtask
  task t_udp;
    {req_udp, req_port} = {1'b1, 16'h1234};
    rq(8'ha8, 0, 1, 16'h0);
    rq(8'ha8, 0, 1, 16'hffff);
    rq(8'ha8, 0, 1, 16'hffff);
    req_port = 16'h1235;
    rq(8'ha8, 0, 1, 16'h0);
    {req_port, go} = {16'h1234, 1'b1};
    @(negedge mclk);
    go = 0;
    for (int i = 0; i < 40 && rsp_done !== 1'b1; i++) @(negedge mclk);
    if (rsp_done !== 1'b1) begin
      fails++;
      test_done;
    end
    // Same-edge answer and request still drops, so wait one cycle
    @(negedge mclk);
    rq(8'ha8, 0, 1, 16'h0);
    $display("udp test done");
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rstn = 1;
    @(negedge mclk);
    t_hdr;
    t_range;
    t_ext;
    t_udp;
    test_done;
  end
endmodule
